// >>> pkg/pmpc_defines.vh
// Purpose: constants for the program memory parity checker
// Assumes: 32-bit apb data, byte addresses as printed
// Notes:   offsets, field positions, reset values and timing counts
`ifndef PMPC_DEFINES_VH
`define PMPC_DEFINES_VH

`define PMPC_OFS_STATUS   32'h01846404
`define PMPC_OFS_COMMAND  32'h01846408
`define PMPC_OFS_ADDRESS  32'h0184640c

`define PMPC_BIT_EN       0
`define PMPC_BIT_DIS      2
`define PMPC_BIT_SUSPEND_MODE     3
`define PMPC_BIT_FETCHERR 5
`define PMPC_BIT_DMA_ERROR_FLAG   6

`define PMPC_ADDR_LSB     5
`define PMPC_RAM_BIT      0

`define PMPC_MODE_EN      3'b001
`define PMPC_MODE_DIS     3'b010
`define PMPC_MODE_SUSPEND_MODE    3'b100
`define PMPC_MODE_RESET   3'b010

`define PMPC_FETCH_LAT    1

`endif

// >>> hw/pmpc_top.v
// Purpose: parity error detection for level one program memory, apb registers
// Assumes: single clock pclk 10 MHz, presetn async active low; parity store inside
// Notes:   fetch result two cycles after data delivered; outputs registered
// Function
// - parity is xor reduction of all 256 read bits, compared with stored bit
// - full writes in enabled mode store parity and valid; other writes outside suspend mark word invalid
// - check only 256-bit wide aligned reads, ram and cache, fetch and dma
// - fetch parity error drives the fetch exception output to the cpu while no fetch error flag is held
// - dma or internal dma error drives separate event to interrupt controller while neither error flag is held
// - status bit 6 dma error, bit 5 fetch error; address captured
// - status bits 0,2,3 show enabled, disabled, suspended mode behaviour
// - exactly one mode indication set at all times
// - fetch and dma error flags never set together
// - status register read only; cpu writes do not change it
// - command bit written 0 does nothing, written 1 triggers action
// - command bit 6 clears dma flag, bit 5 clears fetch flag
// - command bit 3 suspends, bit 2 disables, bit 0 enables
// - more than one mode bit in one write goes to disabled
// - both clears plus one mode bit act together in one write
// - address register holds upper 27 address bits in bits 31-5
// - address bits 4-1 read zero; bit 0 zero for cache error
// - address bit 0 reads one for ram error
// - after reset disabled mode, no error flags
// - record first error only; fetch error overrides a held dma error
// - fetch result signalled within 1 to 2 cycles after data delivered
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`include "pmpc_defines.vh"

module pmpc_top #(
    parameter IDX_W  = 10,
    parameter DATA_W = 256
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [31:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    input  wire              mem_wr,
    input  wire              mem_wr_full,
    input  wire [IDX_W-1:0]  mem_wr_idx,
    input  wire [DATA_W-1:0] mem_wr_data,
    input  wire              rd_valid,
    input  wire              rd_full,
    input  wire              rd_is_fetch,
    input  wire              rd_is_ram,
    input  wire [IDX_W-1:0]  rd_idx,
    input  wire [31:0]       rd_addr,
    input  wire [DATA_W-1:0] rd_data,
    output reg               fetch_error_exc,
    output reg               program_memory_error_event
);

    localparam DEPTH = 1 << IDX_W;

    // parity store: one parity and one valid bit per word
    reg             par_mem   [0:DEPTH-1];
    reg [DEPTH-1:0] valid_r;

    reg [2:0]  mode_r;
    reg        fetch_error_flag_r;
    reg        dma_error_flag_r;
    reg [26:0] err_addr_r;
    reg        err_ram_r;

    // read stage: stored parity lookup and computed parity pipeline
    reg        chk_r;
    reg        chk_fetch_r;
    reg        chk_ram_r;
    reg [26:0] chk_addr_r;
    reg        calc_par_r;
    reg        stored_par_r;
    reg        stored_valid_r;

    wire suspend_mode = mode_r[2];
    wire disable_mode = mode_r[1];
    wire enable_mode  = mode_r[0];

    // parity store update
    always @(posedge pclk) begin
        if (mem_wr && enable_mode && mem_wr_full)
            par_mem[mem_wr_idx] <= ^mem_wr_data;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_r <= {DEPTH{1'b0}};
        end else if (mem_wr && !suspend_mode) begin
            // disabled or narrow writes invalidate, full writes when enabled validate
            valid_r[mem_wr_idx] <= enable_mode & mem_wr_full;
        end
    end

    // stage one: qualify read and capture both parities
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_r          <= 1'b0;
            chk_fetch_r    <= 1'b0;
            chk_ram_r      <= 1'b0;
            chk_addr_r     <= 27'h0000000;
            calc_par_r     <= 1'b0;
            stored_par_r   <= 1'b0;
            stored_valid_r <= 1'b0;
        end else begin
            chk_r          <= rd_valid && rd_full && (rd_addr[4:0] == 5'h00)
                              && enable_mode;
            chk_fetch_r    <= rd_is_fetch;
            chk_ram_r      <= rd_is_ram;
            chk_addr_r     <= rd_addr[31:`PMPC_ADDR_LSB];
            calc_par_r     <= ^rd_data;
            stored_par_r   <= par_mem[rd_idx];
            stored_valid_r <= valid_r[rd_idx];
        end
    end

    wire par_err   = chk_r && stored_valid_r && (calc_par_r != stored_par_r);
    wire fetch_err = par_err && chk_fetch_r;
    wire dma_err   = par_err && !chk_fetch_r;

    // apb decode
    wire apb_acc  = psel && penable;
    wire hit_stat = (paddr == `PMPC_OFS_STATUS);
    wire hit_cmd  = (paddr == `PMPC_OFS_COMMAND);
    wire hit_addr = (paddr == `PMPC_OFS_ADDRESS);
    wire cmd_wr   = apb_acc && !pready && pwrite && hit_cmd;

    wire cmd_en   = cmd_wr && pwdata[`PMPC_BIT_EN];
    wire cmd_dis  = cmd_wr && pwdata[`PMPC_BIT_DIS];
    wire cmd_suspend_mode = cmd_wr && pwdata[`PMPC_BIT_SUSPEND_MODE];
    wire cmd_fclr = cmd_wr && pwdata[`PMPC_BIT_FETCHERR];
    wire cmd_dclr = cmd_wr && pwdata[`PMPC_BIT_DMA_ERROR_FLAG];
    wire [1:0] mode_cnt = {1'b0, cmd_en} + {1'b0, cmd_dis} + {1'b0, cmd_suspend_mode};

    reg [2:0] mode_nxt;
    always @* begin
        mode_nxt = mode_r;
        if (mode_cnt > 2'd1)
            mode_nxt = `PMPC_MODE_DIS;
        else if (cmd_en)
            mode_nxt = `PMPC_MODE_EN;
        else if (cmd_dis)
            mode_nxt = `PMPC_MODE_DIS;
        else if (cmd_suspend_mode)
            mode_nxt = `PMPC_MODE_SUSPEND_MODE;
    end

    // flags after clears; errors arriving in the clear cycle win
    wire f_held = fetch_error_flag_r && !cmd_fclr;
    wire d_held = dma_error_flag_r && !cmd_dclr;
    wire take_fetch = fetch_err && !f_held;
    wire take_dma   = dma_err && !f_held && !d_held;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r                     <= `PMPC_MODE_RESET;
            fetch_error_flag_r         <= 1'b0;
            dma_error_flag_r           <= 1'b0;
            err_addr_r                 <= 27'h0000000;
            err_ram_r                  <= 1'b0;
            fetch_error_exc            <= 1'b0;
            program_memory_error_event <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            if (take_fetch) begin
                fetch_error_flag_r <= 1'b1;
                dma_error_flag_r   <= 1'b0;
                err_addr_r         <= chk_addr_r;
                err_ram_r          <= chk_ram_r;
            end else if (take_dma) begin
                fetch_error_flag_r <= 1'b0;
                dma_error_flag_r   <= 1'b1;
                err_addr_r         <= chk_addr_r;
                err_ram_r          <= chk_ram_r;
            end else begin
                fetch_error_flag_r <= f_held;
                dma_error_flag_r   <= d_held;
            end
            fetch_error_exc            <= take_fetch;
            program_memory_error_event <= take_dma;
        end
    end

    // apb slave: one wait state per access phase, pready pulses for one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= apb_acc && !pready;
            pslverr <= apb_acc && !pready && !(hit_stat || hit_cmd || hit_addr);
            prdata  <= 32'h00000000;
            if (apb_acc && !pready && !pwrite) begin
                if (hit_stat)
                    prdata <= {25'h0000000, dma_error_flag_r, fetch_error_flag_r, 1'b0,
                               suspend_mode, disable_mode, 1'b0, enable_mode};
                else if (hit_addr)
                    prdata <= {err_addr_r, 4'h0, err_ram_r};
            end
        end
    end

endmodule

// >>> sim/pmpc_monitor.sv
// Purpose: port assertions for the parity checker
// Assumes: one pclk domain, presetn active low
// Notes:   bound to pmpc_top
`timescale 1ns/1ns
`include "pmpc_defines.vh"
module pmpc_monitor (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        rd_valid,
    input wire        rd_full,
    input wire        rd_is_fetch,
    input wire [31:0] rd_addr,
    input wire        fetch_error_exc,
    input wire        program_memory_error_event
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_ok = pready && !pwrite && !pslverr;
    wire rd_st = rd_ok && paddr == `PMPC_OFS_STATUS;
    exc_cause_a: assert property (
        fetch_error_exc |-> $past(rd_valid && rd_is_fetch && rd_full, 2))
        else $error("fetch exception without a fetch read");
    evt_cause_a: assert property (
        program_memory_error_event |-> $past(rd_valid && !rd_is_fetch && rd_full, 2))
        else $error("dma event without a dma read");
    aligned_only_a: assert property (
        fetch_error_exc || program_memory_error_event |-> $past(rd_addr[4:0] == 5'h0, 2))
        else $error("error on a misaligned read");
    exc_pulse_a: assert property (fetch_error_exc |=> !fetch_error_exc)
        else $error("second fetch exception while held");
    mode_onehot_a: assert property (rd_st |-> $onehot({prdata[3:2], prdata[0]}))
        else $error("mode bits not one hot");
    flags_excl_a: assert property (rd_st |-> !(prdata[6] && prdata[5]))
        else $error("both error flags set");
    addr_rsvd_a: assert property (
        rd_ok && paddr == `PMPC_OFS_ADDRESS |-> prdata[4:1] == 4'h0)
        else $error("address bits 4-1 not zero");
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
endmodule
bind pmpc_top pmpc_monitor i_mon (.*);

// >>> sim/pmpc_mem_side.sv
// Purpose: fetch and dma side model driving memory writes and reads
// Assumes: one transfer per task call
// Notes:   data lines show inverted values when idle
`timescale 1ns/1ns
module pmpc_mem_side (
    input wire          pclk,
    output reg          mem_wr = 1'b0,
    output reg          mem_wr_full = 1'b0,
    output reg [9:0]    mem_wr_idx = 10'h0,
    output reg [255:0]  mem_wr_data = 256'h0,
    output reg          rd_valid = 1'b0,
    output reg          rd_full = 1'b1,
    output reg          rd_is_fetch = 1'b0,
    output reg          rd_is_ram = 1'b0,
    output reg [9:0]    rd_idx = 10'h0,
    output reg [31:0]   rd_addr = 32'h0,
    output reg [255:0]  rd_data = 256'h0
);
    task wr(input [9:0] i, input [255:0] d, input f);
        @(posedge pclk);
        mem_wr <= 1'b1;
        mem_wr_full <= f;
        mem_wr_idx <= i;
        mem_wr_data <= d;
        @(posedge pclk);
        mem_wr <= 1'b0;
        mem_wr_data <= ~d;
    endtask
    task rd(input [9:0] i, input [255:0] d, input [4:0] lo, input fe, input ram);
        @(posedge pclk);
        rd_valid <= 1'b1;
        rd_is_fetch <= fe;
        rd_is_ram <= ram;
        rd_idx <= i;
        rd_addr <= {17'h00e01, i, lo};
        rd_data <= d;
        @(posedge pclk);
        rd_valid <= 1'b0;
        rd_data <= ~d;
    endtask
endmodule

// >>> sim/program_memory_parity_checker_tb_top.sv
// Purpose: self-checking bench for pmpc_top
// Assumes: apb master here, memory side in pmpc_mem_side
// Notes:   word data 1 has parity 1, data 3 has parity 0
`timescale 1ns/1ns
`include "pmpc_defines.vh"
module program_memory_parity_checker_tb_top;
    reg          pclk = 1'b0;
    reg          presetn = 1'b0;
    reg          psel = 1'b0;
    reg          penable = 1'b0;
    reg          pwrite = 1'b0;
    reg  [31:0]  paddr = 32'h0;
    reg  [31:0]  pwdata = 32'h0;
    reg  [31:0]  rdat;
    reg          rerr;
    wire [31:0]  prdata, rd_addr;
    wire         pready, pslverr, mem_wr, mem_wr_full, rd_valid, rd_full, rd_is_fetch;
    wire         rd_is_ram, fetch_error_exc, program_memory_error_event;
    wire [9:0]   mem_wr_idx, rd_idx;
    wire [255:0] mem_wr_data, rd_data;
    integer      err_total = 0, samples_checked = 0, n_exc = 0, n_evt = 0, cyc = 0;
    localparam [31:0] ST = `PMPC_OFS_STATUS;
    localparam [31:0] AD = `PMPC_OFS_ADDRESS;
    always #50 pclk = ~pclk;
    pmpc_top i_dut (.*);
    pmpc_mem_side i_mem (.*);
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (fetch_error_exc === 1'b1)
            n_exc = n_exc + 1;
        if (program_memory_error_event === 1'b1)
            n_evt = n_evt + 1;
        if (cyc == 5000) begin
            err_total = err_total + 1;
            stop_test;
        end
    end
    task chk(input [31:0] g, input [31:0] e);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input w, input [31:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready === 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rs(input [31:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task cmd(input [31:0] d);
        apb(1'b1, `PMPC_OFS_COMMAND, d);
    endtask
    task evs(input [31:0] x, input [31:0] v);
        repeat (3) @(posedge pclk);
        chk(n_exc, x);
        chk(n_evt, v);
    endtask
    task t_reset;
        rs(ST, 32'h4);
        rs(AD, 32'h0);
        $display("reset test done");
    endtask
    task t_fetch;
        cmd(32'h1);
        rs(ST, 32'h1);
        i_mem.wr(10'd3, 256'h1, 1'b1);
        i_mem.rd(10'd3, 256'h1, 5'h0, 1'b1, 1'b1);
        evs(0, 0);
        i_mem.rd(10'd3, 256'h3, 5'h0, 1'b1, 1'b1);
        evs(1, 0);
        apb(1'b1, ST, 32'hff);
        rs(ST, 32'h21);
        rs(AD, {17'h00e01, 10'd3, 5'h1});
        i_mem.rd(10'd3, 256'h3, 5'h0, 1'b1, 1'b1);
        evs(1, 0);
        $display("fetch test done");
    endtask
    task t_dma;
        cmd(32'h20);
        rs(ST, 32'h1);
        i_mem.wr(10'd5, 256'h1, 1'b0);
        i_mem.rd(10'd5, 256'h3, 5'h0, 1'b0, 1'b0);
        evs(1, 0);
        i_mem.wr(10'd5, 256'h1, 1'b1);
        i_mem.rd(10'd5, 256'h3, 5'h8, 1'b0, 1'b0);
        evs(1, 0);
        i_mem.rd_full <= 1'b0;
        i_mem.rd(10'd5, 256'h3, 5'h0, 1'b0, 1'b0);
        evs(1, 0);
        i_mem.rd_full <= 1'b1;
        i_mem.rd(10'd5, 256'h3, 5'h0, 1'b0, 1'b0);
        evs(1, 1);
        rs(ST, 32'h41);
        rs(AD, {17'h00e01, 10'd5, 5'h0});
        i_mem.rd(10'd3, 256'h3, 5'h0, 1'b1, 1'b1);
        evs(2, 1);
        rs(ST, 32'h21);
        $display("dma test done");
    endtask
    task t_mode;
        cmd(32'h68);
        rs(ST, 32'h8);
        i_mem.rd(10'd3, 256'h3, 5'h0, 1'b1, 1'b1);
        evs(2, 1);
        i_mem.wr(10'd3, 256'h0, 1'b0);
        cmd(32'h1);
        i_mem.rd(10'd3, 256'h3, 5'h0, 1'b1, 1'b1);
        evs(3, 1);
        cmd(32'h28);
        cmd(32'h0);
        rs(ST, 32'h8);
        cmd(32'hd);
        rs(ST, 32'h4);
        apb(1'b0, 32'h01846410, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        $display("mode test done");
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_fetch;
        t_dma;
        t_mode;
        stop_test;
    end
endmodule
